/* uart_regs_defs.svh */
// address, index, field and reset constants of the uart enhanced register access block
`ifndef UART_REGS_DEFS_SVH
`define UART_REGS_DEFS_SVH

// ----------------------------------------------------------------------------
// uart port addresses (3 bit)
// ----------------------------------------------------------------------------
`define ADDR_DATA        3'h0
`define ADDR_IRQ_ENABLE  3'h1
`define ADDR_FIFO_CTRL   3'h2
`define ADDR_LINE_CTRL   3'h3
`define ADDR_MODEM_CTRL  3'h4
`define ADDR_LINE_STAT   3'h5
`define ADDR_MODEM_STAT  3'h6
`define ADDR_SCRATCH     3'h7

// ----------------------------------------------------------------------------
// indexed window offsets held in the scratch/index register
// ----------------------------------------------------------------------------
`define IDX_ADDITIONAL_CONTROL  8'h00
`define IDX_CLOCK_PRESCALER     8'h01
`define IDX_SAMPLE_CLOCK_COUNT  8'h02
`define IDX_CLOCK_SELECT        8'h03
`define IDX_TX_IRQ_THRESHOLD    8'h04
`define IDX_RX_IRQ_THRESHOLD    8'h05
`define IDX_FLOW_LOW_THRESHOLD  8'h06
`define IDX_FLOW_HIGH_THRESHOLD 8'h07
`define IDX_IDENTITY_BYTE_ONE   8'h08

// ----------------------------------------------------------------------------
// field positions and key values
// ----------------------------------------------------------------------------
`define ENH_ACCESS_KEY      8'hBF
`define LC_DIVISOR_BIT      7
`define AC_STATUS_EN_BIT    7
`define AC_WINDOW_RD_BIT    6
`define CKS_ZERO_MASK       8'hFB

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_DIVISOR_LOW     8'h01
`define RST_CLOCK_PRESCALER 8'h20
`define RST_IDENTITY_BYTE   8'h5A   // arbitrary value, names no real part

`endif

/* uart_regs_pkg.sv */
// types of the uart enhanced register access block
package uart_regs_pkg;

    // ------------------------------------------------------------------------
    // enhanced feature register layout
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       cts_flow_en;
        logic       rts_flow_en;
        logic       special_detect;
        logic       enhanced_mode;
        logic [3:0] inband_mode;
    } enhanced_feature_t;

    // ------------------------------------------------------------------------
    // all software-visible control registers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]        line_control_reg;
        logic [7:0]        irq_enable_reg;
        logic [7:0]        modem_control_reg;
        logic [7:0]        scratch_index_reg;
        logic [7:0]        divisor_low;
        logic [7:0]        divisor_high;
        enhanced_feature_t enhanced_feature_reg;
        logic [7:0]        resume_char_one;
        logic [7:0]        resume_char_two;
        logic [7:0]        pause_char_one;
        logic [7:0]        pause_char_two;
        logic [7:0]        additional_control_reg;
        logic [1:0]        tx_disable_ctl;
        logic [7:0]        clock_prescaler;
        logic [3:0]        sample_clock_count;
        logic [7:0]        clock_select;
        logic [6:0]        tx_irq_threshold;
        logic [6:0]        rx_irq_threshold;
        logic [6:0]        flow_low_threshold;
        logic [6:0]        flow_high_threshold;
    } config_t;

    // ------------------------------------------------------------------------
    // status presented by the uart core
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] rx_data;
        logic [7:0] irq_status;
        logic [7:0] line_status;
        logic [7:0] modem_status;
        logic [7:0] rx_fifo_level;
        logic [7:0] tx_fifo_level;
        logic       tx_idle;
        logic       fifo_size;
        logic       fifo_sel;
        logic       special_seen;
        logic       dtr_state;
        logic       rts_state;
    } core_status_t;

    // ------------------------------------------------------------------------
    // decoded register bank
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        BANK_NORMAL   = 2'b00,
        BANK_DIVISOR  = 2'b01,
        BANK_ENHANCED = 2'b10
    } bank_t;

    // ------------------------------------------------------------------------
    // whole module state
    // ------------------------------------------------------------------------
    typedef struct packed {
        config_t    cfg;
        logic [7:0] rd_data;
        logic       rd_valid;
        logic       rx_pop;
        logic       tx_push;
        logic       fifo_ctrl_wr;
        logic [7:0] wr_data;
    } state_t;

endpackage

/* uart_regs.sv */
// register decode and bank switching of the uart enhanced register set
//
// Overview of operation
// - line control at 0xBF maps addresses 2,4,5,6,7 to enhanced feature and flow chars.
// - fifo levels, window and flagged registers are hidden while line control holds 0xBF.
// - status, levels, window and irq enable decode only while line control bit 7 is low.
// - additional status at 1 and both fifo levels need additional control bit 7 set.
// - irq enable at 1 is reachable only while additional control bit 7 is zero.
// - additional status reports six status bits over bits 1 and 0, the only bits that take writes.
// - in the normal bank with additional control bit 7 set, reads at 3 and 4 return the receive and transmit fifo fill counts, read only.
// - a read at 5 returns the indexed register only while additional control bit 6 is one.
// - address 5 is a window onto the indexed register chosen by the scratch/index register.
// - in the normal bank, line status is read at 5 only while additional control bit 6 is zero.
// - in the normal bank, line and modem control read back only while additional control bit 7 is zero.
// - reset clears every writable register except divisor low to 1 and prescaler to 0x20.
`timescale 1ns/1ps
`default_nettype none
`include "uart_regs_defs.svh"

module uart_regs
    import uart_regs_pkg::*;
(
    // clock, reset, enable
    input  wire logic         core_clk_in,
    input  wire logic         reset_n_in,
    input  wire logic         clk_en_in,
    // uart register port
    input  wire logic [2:0]   addr_in,
    input  wire logic         wr_in,
    input  wire logic         rd_in,
    input  wire logic [7:0]   wr_data_in,
    output logic      [7:0]   rd_data_out,
    output logic              rd_valid_out,
    // uart core side
    input  wire core_status_t status_in,
    output config_t           config_out,
    output logic              rx_pop_out,
    output logic              tx_push_out,
    output logic              fifo_ctrl_wr_out,
    output logic      [7:0]   wr_data_out
);

    // ------------------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------------------
    state_t     s_q;
    state_t     s_d;
    bank_t      bank;
    logic       enh_key;
    logic       status_en;
    logic       window_rd;
    logic [7:0] window_rd_data;
    logic [7:0] rd_mux;

    // bank follows the stored line control value, so "last write" is what it holds
    always_comb begin
        enh_key   = (s_q.cfg.line_control_reg == `ENH_ACCESS_KEY);
        status_en = s_q.cfg.additional_control_reg[`AC_STATUS_EN_BIT];
        window_rd = s_q.cfg.additional_control_reg[`AC_WINDOW_RD_BIT];
        if (enh_key) begin
            bank = BANK_ENHANCED;
        end else if (s_q.cfg.line_control_reg[`LC_DIVISOR_BIT]) begin
            bank = BANK_DIVISOR;
        end else begin
            bank = BANK_NORMAL;
        end
    end

    // ------------------------------------------------------------------------
    // indexed window read side
    // ------------------------------------------------------------------------
    // unlisted offsets read as zero rather than aliasing another register
    always_comb begin
        case (s_q.cfg.scratch_index_reg)
            `IDX_ADDITIONAL_CONTROL:  window_rd_data = s_q.cfg.additional_control_reg;
            `IDX_CLOCK_PRESCALER:     window_rd_data = s_q.cfg.clock_prescaler;
            `IDX_SAMPLE_CLOCK_COUNT:  window_rd_data = {4'h0, s_q.cfg.sample_clock_count};
            `IDX_CLOCK_SELECT:        window_rd_data = s_q.cfg.clock_select;
            `IDX_TX_IRQ_THRESHOLD:    window_rd_data = {1'b0, s_q.cfg.tx_irq_threshold};
            `IDX_RX_IRQ_THRESHOLD:    window_rd_data = {1'b0, s_q.cfg.rx_irq_threshold};
            `IDX_FLOW_LOW_THRESHOLD:  window_rd_data = {1'b0, s_q.cfg.flow_low_threshold};
            `IDX_FLOW_HIGH_THRESHOLD: window_rd_data = {1'b0, s_q.cfg.flow_high_threshold};
            `IDX_IDENTITY_BYTE_ONE:   window_rd_data = `RST_IDENTITY_BYTE;  // arbitrary value
            default:                  window_rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // read multiplexer
    // ------------------------------------------------------------------------
    always_comb begin
        rd_mux = 8'h00;
        case (addr_in)
            `ADDR_DATA: begin
                rd_mux = (bank == BANK_NORMAL) ? status_in.rx_data : s_q.cfg.divisor_low;
            end
            `ADDR_IRQ_ENABLE: begin
                if (bank != BANK_NORMAL) begin
                    rd_mux = s_q.cfg.divisor_high;
                end else if (status_en) begin
                    rd_mux = {status_in.tx_idle, status_in.fifo_size, status_in.fifo_sel,
                              status_in.special_seen, status_in.dtr_state,
                              status_in.rts_state, s_q.cfg.tx_disable_ctl};
                end else begin
                    rd_mux = s_q.cfg.irq_enable_reg;
                end
            end
            `ADDR_FIFO_CTRL: begin
                rd_mux = (bank == BANK_ENHANCED) ? s_q.cfg.enhanced_feature_reg
                                                 : status_in.irq_status;
            end
            `ADDR_LINE_CTRL: begin
                // fill count replaces line control readback while status is enabled
                if (bank == BANK_NORMAL && status_en) begin
                    rd_mux = status_in.rx_fifo_level;
                end else begin
                    rd_mux = s_q.cfg.line_control_reg;
                end
            end
            `ADDR_MODEM_CTRL: begin
                if (bank == BANK_ENHANCED) begin
                    rd_mux = s_q.cfg.resume_char_one;
                end else if (bank == BANK_NORMAL && status_en) begin
                    rd_mux = status_in.tx_fifo_level;
                end else begin
                    rd_mux = s_q.cfg.modem_control_reg;
                end
            end
            `ADDR_LINE_STAT: begin
                if (bank == BANK_ENHANCED) begin
                    rd_mux = s_q.cfg.resume_char_two;
                end else if (bank == BANK_NORMAL && window_rd) begin
                    rd_mux = window_rd_data;
                end else begin
                    rd_mux = status_in.line_status;
                end
            end
            `ADDR_MODEM_STAT: begin
                rd_mux = (bank == BANK_ENHANCED) ? s_q.cfg.pause_char_one
                                                 : status_in.modem_status;
            end
            `ADDR_SCRATCH: begin
                rd_mux = (bank == BANK_ENHANCED) ? s_q.cfg.pause_char_two
                                                 : s_q.cfg.scratch_index_reg;
            end
            default: rd_mux = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------------
    // next state: writes, read capture and core strobes
    // ------------------------------------------------------------------------
    always_comb begin
        s_d              = s_q;
        s_d.rd_valid     = 1'b0;
        s_d.rx_pop       = 1'b0;
        s_d.tx_push      = 1'b0;
        s_d.fifo_ctrl_wr = 1'b0;
        if (rd_in) begin
            s_d.rd_data  = rd_mux;
            s_d.rd_valid = 1'b1;
            s_d.rx_pop   = (addr_in == `ADDR_DATA) && (bank == BANK_NORMAL);
        end
        if (wr_in) begin
            s_d.wr_data = wr_data_in;
            case (addr_in)
                `ADDR_DATA: begin
                    if (bank == BANK_NORMAL) begin
                        s_d.tx_push = 1'b1;
                    end else begin
                        s_d.cfg.divisor_low = wr_data_in;
                    end
                end
                `ADDR_IRQ_ENABLE: begin
                    if (bank != BANK_NORMAL) begin
                        s_d.cfg.divisor_high = wr_data_in;
                    end else if (status_en) begin
                        s_d.cfg.tx_disable_ctl = wr_data_in[1:0];
                    end else begin
                        s_d.cfg.irq_enable_reg = wr_data_in;
                    end
                end
                `ADDR_FIFO_CTRL: begin
                    if (bank == BANK_ENHANCED) begin
                        s_d.cfg.enhanced_feature_reg = wr_data_in;
                    end else begin
                        s_d.fifo_ctrl_wr = 1'b1;
                    end
                end
                // line control always writable: it is the only way out of the enhanced bank
                `ADDR_LINE_CTRL: s_d.cfg.line_control_reg = wr_data_in;
                `ADDR_MODEM_CTRL: begin
                    if (bank == BANK_ENHANCED) begin
                        s_d.cfg.resume_char_one = wr_data_in;
                    end else begin
                        s_d.cfg.modem_control_reg = wr_data_in;
                    end
                end
                `ADDR_LINE_STAT: begin
                    if (bank == BANK_ENHANCED) begin
                        s_d.cfg.resume_char_two = wr_data_in;
                    end else if (bank == BANK_NORMAL) begin
                        // window write goes by index regardless of the read enable
                        case (s_q.cfg.scratch_index_reg)
                            `IDX_ADDITIONAL_CONTROL:
                                s_d.cfg.additional_control_reg = wr_data_in;
                            `IDX_CLOCK_PRESCALER:
                                s_d.cfg.clock_prescaler = wr_data_in;
                            `IDX_SAMPLE_CLOCK_COUNT:
                                s_d.cfg.sample_clock_count = wr_data_in[3:0];
                            `IDX_CLOCK_SELECT:
                                s_d.cfg.clock_select = wr_data_in & `CKS_ZERO_MASK;
                            `IDX_TX_IRQ_THRESHOLD:
                                s_d.cfg.tx_irq_threshold = wr_data_in[6:0];
                            `IDX_RX_IRQ_THRESHOLD:
                                s_d.cfg.rx_irq_threshold = wr_data_in[6:0];
                            `IDX_FLOW_LOW_THRESHOLD:
                                s_d.cfg.flow_low_threshold = wr_data_in[6:0];
                            `IDX_FLOW_HIGH_THRESHOLD:
                                s_d.cfg.flow_high_threshold = wr_data_in[6:0];
                            default: ;
                        endcase
                    end
                end
                `ADDR_MODEM_STAT: begin
                    if (bank == BANK_ENHANCED) begin
                        s_d.cfg.pause_char_one = wr_data_in;
                    end
                end
                `ADDR_SCRATCH: begin
                    if (bank == BANK_ENHANCED) begin
                        s_d.cfg.pause_char_two = wr_data_in;
                    end else begin
                        s_d.cfg.scratch_index_reg = wr_data_in;
                    end
                end
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    // clock enable low freezes everything, strobes included
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q                     <= '0;
            s_q.cfg.divisor_low     <= `RST_DIVISOR_LOW;
            s_q.cfg.clock_prescaler <= `RST_CLOCK_PRESCALER;
        end else if (clk_en_in) begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs straight from the state register
    // ------------------------------------------------------------------------
    assign rd_data_out      = s_q.rd_data;
    assign rd_valid_out     = s_q.rd_valid;
    assign config_out       = s_q.cfg;
    assign rx_pop_out       = s_q.rx_pop;
    assign tx_push_out      = s_q.tx_push;
    assign fifo_ctrl_wr_out = s_q.fifo_ctrl_wr;
    assign wr_data_out      = s_q.wr_data;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    // requests only count on enabled edges
    logic wr_go;
    logic rd_go;
    assign wr_go = clk_en_in && wr_in;
    assign rd_go = clk_en_in && rd_in;

    // bank decode checks; read data is held against pre-edge state via $past
    efr_write_a: assert property (wr_go && enh_key && addr_in == `ADDR_FIFO_CTRL |=>
        s_q.cfg.enhanced_feature_reg == $past(wr_data_in) && !fifo_ctrl_wr_out)
        else $error("enhanced feature write lost");
    efr_guard_a: assert property (wr_go && !enh_key && addr_in == `ADDR_FIFO_CTRL |=>
        $stable(s_q.cfg.enhanced_feature_reg) && fifo_ctrl_wr_out)
        else $error("enhanced feature changed outside its bank");
    tfl_hidden_a: assert property (rd_go && enh_key && addr_in == `ADDR_MODEM_CTRL |=>
        rd_valid_out && rd_data_out == $past(s_q.cfg.resume_char_one))
        else $error("flow character not returned in enhanced bank");
    divisor_bank_a: assert property (rd_go && !enh_key && s_q.cfg.line_control_reg[7]
        && addr_in == `ADDR_IRQ_ENABLE |=> rd_data_out == $past(s_q.cfg.divisor_high))
        else $error("divisor high not returned");
    // status, level and window checks
    asr_read_a: assert property (rd_go && bank == BANK_NORMAL && status_en
        && addr_in == `ADDR_IRQ_ENABLE |=> rd_data_out[1:0] == $past(s_q.cfg.tx_disable_ctl)
        && rd_data_out[7] == $past(status_in.tx_idle))
        else $error("additional status read wrong");
    ier_guard_a: assert property (wr_go && bank == BANK_NORMAL && status_en
        && addr_in == `ADDR_IRQ_ENABLE |=> $stable(s_q.cfg.irq_enable_reg)
        && s_q.cfg.tx_disable_ctl == $past(wr_data_in[1:0]))
        else $error("irq enable written while status enabled");
    rfl_read_a: assert property (rd_go && bank == BANK_NORMAL && status_en
        && addr_in == `ADDR_LINE_CTRL |=> rd_data_out == $past(status_in.rx_fifo_level))
        else $error("receive level not returned");
    window_read_a: assert property (rd_go && bank == BANK_NORMAL
        && addr_in == `ADDR_LINE_STAT |=> rd_data_out == ($past(window_rd) ? $past(window_rd_data)
        : $past(status_in.line_status)))
        else $error("window or line status read wrong");
    window_write_a: assert property (wr_go && bank == BANK_NORMAL
        && addr_in == `ADDR_LINE_STAT && s_q.cfg.scratch_index_reg == `IDX_TX_IRQ_THRESHOLD
        |=> s_q.cfg.tx_irq_threshold == $past(wr_data_in[6:0]))
        else $error("window write did not reach threshold");
    lcr_read_a: assert property (rd_go && bank == BANK_NORMAL && !status_en
        && addr_in == `ADDR_LINE_CTRL |=> rd_data_out == $past(s_q.cfg.line_control_reg))
        else $error("line control readback wrong");
    threshold_msb_a: assert property (rd_go && bank == BANK_NORMAL && window_rd
        && addr_in == `ADDR_LINE_STAT && s_q.cfg.scratch_index_reg[7:2] == 6'h01
        |=> !rd_data_out[7])
        else $error("threshold bit 7 not zero");
    // clock enable low must hold every flop, strobes included
    freeze_a: assert property (!clk_en_in |=> $stable(s_q))
        else $error("state moved while clock enable low");
    reset_value_a: assert property ($rose(reset_n_in) |-> !rd_valid_out
        && config_out.divisor_low == `RST_DIVISOR_LOW
        && config_out.clock_prescaler == `RST_CLOCK_PRESCALER)
        else $error("reset values wrong");
    tx_push_a: assert property (wr_go && bank == BANK_NORMAL && addr_in == `ADDR_DATA
        |=> tx_push_out && wr_data_out == $past(wr_data_in))
        else $error("transmit push missing");

    enter_enh_c:  cover property (wr_go && addr_in == `ADDR_LINE_CTRL
                                  && wr_data_in == `ENH_ACCESS_KEY ##1 wr_go);
    window_rd_c:  cover property (rd_go && bank == BANK_NORMAL && window_rd
                                  && addr_in == `ADDR_LINE_STAT);
    status_rd_c:  cover property (rd_go && bank == BANK_NORMAL && status_en
                                  && addr_in == `ADDR_MODEM_CTRL);
    freeze_c:     cover property (!clk_en_in && wr_in);
    divisor_rd_c: cover property (rd_go && bank == BANK_DIVISOR);

endmodule // uart_regs
`default_nettype wire

/* uart_regs_tb.sv */
// self-checking bench for the uart enhanced register access block
`timescale 1ns/1ps
`default_nettype none
module uart_regs_tb import uart_regs_pkg::*;;
    // ----------------------------------------------------------------
    // stimulus and observation
    // ----------------------------------------------------------------
    logic         core_clk_in = 1'b0;
    logic         reset_n_in  = 1'b0;
    logic [2:0]   addr_in     = 3'h0;
    logic         wr_in       = 1'b0;
    logic         rd_in       = 1'b0;
    logic [7:0]   wr_data_in  = 8'h00;
    core_status_t status_in   = '0;
    logic [7:0]   rd_data_out;
    logic [7:0]   v [8];
    logic         rd_valid_out;
    config_t      config_out;
    logic [7:0]   exp_q [$];
    logic [63:0]  r;
    int           seed = 70183;
    int           n_mismatch = 0;
    int           check_count = 0;
    logic         clk_en_in   = 1'b1;
    logic         rx_pop_out;
    logic         tx_push_out;
    logic         fifo_ctrl_wr_out;
    logic [7:0]   wr_data_out;
    logic [15:0]  stb_q [$];
    logic [15:0]  note;

    uart_regs DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
        .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wr_data_in(wr_data_in),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .status_in(status_in),
        .config_out(config_out), .rx_pop_out(rx_pop_out), .tx_push_out(tx_push_out),
        .fifo_ctrl_wr_out(fifo_ctrl_wr_out), .wr_data_out(wr_data_out));

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one-cycle strobes, dropped a full cycle later so no edge sees a glitch
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge core_clk_in);
        {wr_in, addr_in, wr_data_in} = {1'b1, a, d};
        @(negedge core_clk_in);
        wr_in = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(negedge core_clk_in);
        {rd_in, addr_in} = {1'b1, a};
        exp_q.push_back(e);
        @(negedge core_clk_in);
        rd_in = 1'b0;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial forever #4 core_clk_in = ~core_clk_in;
    // read and strobe monitor: settle past the edge, then match the oldest note
    always @(posedge core_clk_in) begin
        #1;
        if (rd_valid_out === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected read", 8'h00, 8'hFF);
            else chk("rd_data_out", exp_q.pop_front(), rd_data_out);
        end
        if ({tx_push_out, fifo_ctrl_wr_out, rx_pop_out} !== 3'b000) begin
            note = stb_q.size() ? stb_q.pop_front() : 16'hFFFF;
            chk("strobes", note[15:8],
                {5'h00, tx_push_out, fifo_ctrl_wr_out, rx_pop_out});
            chk("wr_data_out", note[7:0], wr_data_out);
        end
    end
    initial begin
        repeat (3000) @(posedge core_clk_in);
        n_mismatch++;
        summarize();
    end

    initial begin
        r = {$random(seed), $random(seed)};
        status_in = r[53:0];
        repeat (2) @(negedge core_clk_in);
        reset_n_in = 1'b1;
        chk("divisor_low", 8'h01, config_out.divisor_low);
        chk("clock_prescaler", 8'h20, config_out.clock_prescaler);
        // enhanced bank: feature register and four flow characters
        wr(3'h3, 8'hBF);
        for (int i = 2; i < 8; i++) if (i != 3) begin
            v[i] = 8'($random(seed));
            wr(3'(i), v[i]);
        end
        for (int i = 2; i < 8; i++) if (i != 3) rd(3'(i), v[i]);
        chk("enhanced_feature_reg", v[2], config_out.enhanced_feature_reg);
        chk("additional_control", 8'h00, config_out.additional_control_reg);
        // normal bank with status and levels enabled
        wr(3'h3, 8'h03);
        wr(3'h7, 8'h00);
        wr(3'h5, 8'hC0);
        wr(3'h1, 8'hFF);
        rd(3'h1, {status_in[5:0], 2'b11});
        rd(3'h3, status_in.rx_fifo_level);
        rd(3'h4, status_in.tx_fifo_level);
        wr(3'h7, 8'h04);
        wr(3'h5, 8'hFF);
        rd(3'h5, 8'h7F);
        wr(3'h7, 8'h00);
        wr(3'h5, 8'h00);
        // clock enable low: a write must not land
        @(negedge core_clk_in);
        clk_en_in = 1'b0;
        wr(3'h7, 8'h55);
        clk_en_in = 1'b1;
        rd(3'h7, 8'h00);
        rd(3'h5, status_in.line_status);
        rd(3'h3, 8'h03);
        v[1] = 8'($random(seed));
        wr(3'h1, v[1]);
        rd(3'h1, v[1]);
        // divisor bank hides irq enable
        wr(3'h3, 8'h83);
        wr(3'h1, ~v[1]);
        rd(3'h1, ~v[1]);
        wr(3'h3, 8'h03);
        rd(3'h1, v[1]);
        // core strobes in the normal bank
        v[0] = 8'($random(seed));
        stb_q.push_back({8'h04, v[0]});
        wr(3'h0, v[0]);
        stb_q.push_back({8'h02, 8'hA5});
        wr(3'h2, 8'hA5);
        stb_q.push_back({8'h01, 8'hA5});
        rd(3'h0, status_in.rx_data);
        repeat (3) @(negedge core_clk_in);
        chk("pending reads", 8'h00, 8'(exp_q.size()));
        chk("pending strobes", 8'h00, 8'(stb_q.size()));
        summarize();
    end
endmodule // uart_regs_tb
`default_nettype wire
